// *** include/psq_pkg.sv ***
/*
 * psq_pkg: constants, register map, state codes and pin carriers for the
 * pushbutton power sequencer.
 * Assumes a single 250 MHz clock and an AXI4-Lite master with 32-bit data.
 */
`default_nettype none
package psq_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_KHZ      = 250000;        // 250 MHz core clock
   localparam int unsigned DEBOUNCE_MS  = 24;            // key debounce interval
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
   localparam int unsigned DISCH_CYC    = 16;            // active discharge hold time
   localparam logic [31:0] RST_DELAY_DEF = 32'h0000_1000; // reset delay after power good
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_RST_DELAY = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_INT_STAT  = 8'h0c;
   localparam logic [7:0] REG_INT_MASK  = 8'h10;
   localparam int unsigned NUM_EVT      = 4;
   localparam logic [1:0] RESP_OKAY     = 2'b00;
   localparam logic [1:0] RESP_SLVERR   = 2'b10;
   // interrupt event bit positions
   localparam int unsigned EVT_PRESS    = 0;
   localparam int unsigned EVT_READY    = 1;
   localparam int unsigned EVT_SHUTDOWN = 2;
   localparam int unsigned EVT_FAULT    = 3;
   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      PSQ_OFF   = 3'b000,
      PSQ_SEQ1  = 3'b001,
      PSQ_SEQ2  = 3'b010,
      PSQ_SEQ3  = 3'b011,
      PSQ_RDLY  = 3'b100,
      PSQ_RUN   = 3'b101,
      PSQ_DISCH = 3'b110
   } psq_state_t;
   // ==========================================================
   // pin carriers; converter index 0 = buck one, 1 = buck two, 2 = buck-boost
   typedef struct packed {
      logic       key_input;       // pushbutton, low = pressed
      logic       hold_on_input;   // processor hold
      logic       pwm_select;      // high = fixed-frequency switching
      logic [2:0] conv_enable;     // buckboost_enable, buck_two_enable, buck_one_enable
      logic [2:0] power_good;      // per-converter regulation flag
      logic       fault;
      logic       bat_present;
      logic       adp_present;
      logic       adp_higher;      // adapter above battery
   } psq_in_t;
   typedef struct packed {
      logic [2:0] conv_on;
      logic       force_pwm;       // all converters fixed frequency
      logic       buck_auto_skip;  // bucks may pulse-skip at light load
      logic       bb_skip_only;    // buck-boost pulse-skip only, light load
      logic       discharge;       // actively discharge all outputs
      logic       ldo_on;
      logic       max_on;
      logic       max_from_adp;
   } psq_rail_t;
endpackage
`default_nettype wire

// *** rtl/psq_top.sv ***
/*
 * psq_top: pushbutton power sequencer with AXI4-Lite register slave.
 * Assumes pin inputs are asynchronous (two-flop synchronised here), and that
 * the board resolves the open-drain button status pin from its enable.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
// Contract
// - select high: every converter runs fixed-frequency switching
// - select low: buck-boost pulse-skips only, light load
// - select low: bucks move between pulse-skip and fixed frequency automatically
// - hold input high enables the device without any key press
// - key low starts the power-up order and a processor reset
// - debounced open-drain button status shows key state
// - reset held until all enabled converters regulate, then programmed delay
// - reset held low during fault and while disabled
// - protected load connects only after buck-boost regulates
// - converter enable allows turn-on only while device enabled; low keeps off
// - always-alive regulator on whenever either supply is present
// - tracking output follows higher supply whenever either is present
// - key must stay low for the debounce interval before acting
// - buck one, then buck two on its power good, then buck-boost
// - hold low when key released: disable and discharge all outputs
// - disabled converters are skipped in the power-up order
module psq_top
   import psq_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire psq_in_t     pins,
   output var  psq_rail_t   rails,
   output var  logic        protected_load_output,
   output var  logic        proc_reset_n,
   output var  logic        button_state_out_o,
   output var  logic        button_state_out_oe,
   output var  logic        irq
);
   // ==========================================================
   // input synchronisers: stage one is read only by stage two
   psq_in_t sync1;
   psq_in_t sync2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= '{key_input: 1'b1, default: '0}; // released level, no false press after reset
         sync2 <= '{key_input: 1'b1, default: '0};
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   // ==========================================================
   // key debounce: press must last the full interval, release is immediate
   logic [22:0] deb_cnt;
   logic [22:0] next_deb_cnt;
   logic        key_db;
   logic        next_key_db;
   always_comb begin
      next_deb_cnt = deb_cnt;
      next_key_db  = key_db;
      if (sync2.key_input) begin
         next_deb_cnt = '0;
         next_key_db  = 1'b0;
      end else if (32'(deb_cnt) + 32'd1 >= DEBOUNCE_CYCLES) begin
         next_key_db  = 1'b1;
      end else begin
         next_deb_cnt = deb_cnt + 23'd1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deb_cnt <= '0;
         key_db  <= 1'b0;
      end else begin
         deb_cnt <= next_deb_cnt;
         key_db  <= next_key_db;
      end
   end

   // ==========================================================
   // sequencer
   psq_state_t  state;
   psq_state_t  next_state;
   logic [31:0] dly_cnt;
   logic [31:0] next_dly_cnt;
   logic [31:0] rst_delay;
   logic [2:0]  ena;
   logic [2:0]  pg;
   logic        dev_en;
   logic        all_pg;
   assign ena    = sync2.conv_enable;
   assign pg     = sync2.power_good;
   assign dev_en = sync2.hold_on_input | key_db;
   assign all_pg = &(pg | ~ena);
   always_comb begin
      next_state   = state;
      next_dly_cnt = dly_cnt;
      case (state)
         PSQ_OFF: begin
            if (dev_en) next_state = PSQ_SEQ1;
         end
         PSQ_SEQ1: begin
            if (pg[0] || !ena[0]) next_state = PSQ_SEQ2;
         end
         PSQ_SEQ2: begin
            if (pg[1] || !ena[1]) next_state = PSQ_SEQ3;
         end
         PSQ_SEQ3: begin
            if (pg[2] || !ena[2]) begin
               next_state   = PSQ_RDLY;
               next_dly_cnt = '0;
            end
         end
         PSQ_RDLY: begin
            // a rail dropping out of regulation restarts the delay
            if (!all_pg) next_dly_cnt = '0;
            else if (dly_cnt >= rst_delay) next_state = PSQ_RUN;
            else next_dly_cnt = dly_cnt + 32'd1;
         end
         PSQ_RUN: ;
         PSQ_DISCH: begin
            if (dly_cnt >= 32'(DISCH_CYC)) next_state = PSQ_OFF;
            else next_dly_cnt = dly_cnt + 32'd1;
         end
         default: next_state = PSQ_OFF;
      endcase
      // releasing the key without hold shuts everything down
      if (state != PSQ_OFF && state != PSQ_DISCH && !dev_en) begin
         next_state   = PSQ_DISCH;
         next_dly_cnt = '0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state   <= PSQ_OFF;
         dly_cnt <= '0;
      end else begin
         state   <= next_state;
         dly_cnt <= next_dly_cnt;
      end
   end

   // ==========================================================
   // pin outputs, all registered
   logic [2:0] stage;
   always_comb begin
      case (state)
         PSQ_SEQ1: stage = 3'b001;
         PSQ_SEQ2: stage = 3'b011;
         PSQ_SEQ3, PSQ_RDLY, PSQ_RUN: stage = 3'b111;
         default:  stage = 3'b000;
      endcase
   end
   psq_rail_t next_rails;
   always_comb begin
      next_rails                = '0;
      next_rails.conv_on        = stage & ena;
      next_rails.force_pwm      = sync2.pwm_select;
      next_rails.buck_auto_skip = !sync2.pwm_select;
      next_rails.bb_skip_only   = !sync2.pwm_select;
      next_rails.discharge      = (state == PSQ_DISCH);
      next_rails.ldo_on         = sync2.bat_present | sync2.adp_present;
      next_rails.max_on         = sync2.bat_present | sync2.adp_present;
      next_rails.max_from_adp   = sync2.adp_present & (sync2.adp_higher | !sync2.bat_present);
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rails                 <= '0;
         protected_load_output <= 1'b0;
         proc_reset_n          <= 1'b0;
         button_state_out_o    <= 1'b0;
         button_state_out_oe   <= 1'b0;
      end else begin
         rails                 <= next_rails;
         // buck-boost must regulate before the load switch closes
         protected_load_output <= (state == PSQ_RDLY || state == PSQ_RUN) && ena[2] && pg[2];
         proc_reset_n          <= (state == PSQ_RUN) && !sync2.fault;
         button_state_out_o    <= 1'b0;
         button_state_out_oe   <= key_db;
      end
   end

   // ==========================================================
   // events and interrupt
   logic                key_db_d;
   logic                fault_d;
   logic [NUM_EVT-1:0]  evt;
   logic [NUM_EVT-1:0]  int_stat;
   logic [NUM_EVT-1:0]  int_mask;
   logic [NUM_EVT-1:0]  next_int_stat;
   logic [NUM_EVT-1:0]  next_int_mask;
   logic [NUM_EVT-1:0]  stat_clr;
   always_comb begin
      evt               = '0;
      evt[EVT_PRESS]    = key_db & !key_db_d;
      evt[EVT_READY]    = (next_state == PSQ_RUN) && (state != PSQ_RUN);
      evt[EVT_SHUTDOWN] = (next_state == PSQ_DISCH) && (state != PSQ_DISCH);
      evt[EVT_FAULT]    = sync2.fault & !fault_d;
      // a new event wins over a clear in the same cycle
      next_int_stat     = (int_stat & ~stat_clr) | evt;
   end

   // ==========================================================
   // AXI4-Lite slave: write address and data latched separately
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic [31:0] rd_word;
   logic [31:0] delay_merged;
   logic        rd_hit;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   always_comb begin
      stat_clr      = '0;
      next_int_mask = int_mask;
      delay_merged  = rst_delay;
      for (int b = 0; b < 4; b++) begin
         if (w_strb[b]) delay_merged[8*b +: 8] = w_data[8*b +: 8];
      end
      if (do_write && w_strb[0]) begin
         if (aw_addr == REG_INT_STAT) stat_clr = w_data[NUM_EVT-1:0];
         if (aw_addr == REG_INT_MASK) next_int_mask = w_data[NUM_EVT-1:0];
      end
   end
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = '0;
      case (s_axi_araddr)
         REG_CTRL:      rd_word = 32'(dev_en);
         REG_RST_DELAY: rd_word = rst_delay;
         REG_STATUS:    rd_word = {16'h0000, proc_reset_n, protected_load_output, key_db,
                                   sync2.hold_on_input, pg, ena, state, rails.conv_on};
         REG_INT_STAT:  rd_word = 32'(int_stat);
         REG_INT_MASK:  rd_word = 32'(int_mask);
         default:       rd_hit  = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         rst_delay     <= RST_DELAY_DEF;
         int_stat      <= '0;
         int_mask      <= '0;
         key_db_d      <= 1'b0;
         fault_d       <= 1'b0;
         irq           <= 1'b0;
      end else begin
         // ready pulses one cycle per accepted beat
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == REG_CTRL || aw_addr == REG_RST_DELAY || aw_addr == REG_STATUS ||
                             aw_addr == REG_INT_STAT || aw_addr == REG_INT_MASK) ? RESP_OKAY : RESP_SLVERR;
            if (aw_addr == REG_RST_DELAY) rst_delay <= delay_merged;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         int_stat <= next_int_stat;
         int_mask <= next_int_mask;
         key_db_d <= key_db;
         fault_d  <= sync2.fault;
         irq      <= |(next_int_stat & next_int_mask);
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_mode_fixed;
      rails.force_pwm == $past(sync2.pwm_select);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed) else $error("fixed-frequency mode does not follow select");
   property p_mode_skip;
      rails.force_pwm |-> !rails.bb_skip_only && !rails.buck_auto_skip;
   endproperty
   a_mode_skip: assert property (p_mode_skip) else $error("skip modes active with select high");
   property p_reset_run;
      proc_reset_n |-> $past(state) == PSQ_RUN;
   endproperty
   a_reset_run: assert property (p_reset_run) else $error("reset released outside run state");
   property p_reset_fault;
      sync2.fault |=> !proc_reset_n;
   endproperty
   a_reset_fault: assert property (p_reset_fault) else $error("reset released during fault");
   property p_load_pg;
      protected_load_output |-> $past(pg[2]) && $past(ena[2]);
   endproperty
   a_load_pg: assert property (p_load_pg) else $error("load switched without buck-boost regulation");
   property p_conv_ena;
      $rose(rails.conv_on[1]) |-> $past(ena[1]) && ($past(pg[0], 2) || !$past(ena[0], 2));
   endproperty
   a_conv_ena: assert property (p_conv_ena) else $error("buck two started out of order");
   property p_release_off;
      (state == PSQ_RUN && !dev_en) |=> state == PSQ_DISCH ##1 rails.discharge && !proc_reset_n;
   endproperty
   a_release_off: assert property (p_release_off) else $error("no discharge after release without hold");
   property p_ldo;
      (sync2.bat_present || sync2.adp_present) |=> rails.ldo_on && rails.max_on;
   endproperty
   a_ldo: assert property (p_ldo) else $error("always-alive outputs off with supply present");
   property p_debounce;
      $rose(key_db) |-> $past(!sync2.key_input) && 32'(deb_cnt) + 32'd1 >= DEBOUNCE_CYCLES;
   endproperty
   a_debounce: assert property (p_debounce) else $error("button accepted before debounce interval");
   property p_start;
      (state == PSQ_OFF && dev_en) |=> state == PSQ_SEQ1 ##1 rails.conv_on[0] == $past(ena[0]);
   endproperty
   a_start: assert property (p_start) else $error("power-up did not start");
   c_run: cover property (state == PSQ_SEQ3 ##[1:300] state == PSQ_RUN);
   c_skip: cover property (state == PSQ_SEQ2 && !ena[1] ##1 state == PSQ_SEQ3);
   c_disch: cover property (state == PSQ_DISCH ##1 state == PSQ_DISCH);
endmodule
`default_nettype wire

// *** verification/psq_host_model.sv ***
/*
 * psq_host_model: far side of the sequencer, converter power-good ramps
 * and a host processor that takes over the hold input.
 * Assumes the same single clock and synchronous active-low reset as the design.
 */
`default_nettype none
module psq_host_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [2:0] conv_on,
   input  wire logic       proc_reset_n,
   input  wire logic       button_level,
   input  wire logic       host_en,
   input  wire logic       slow,
   output var  logic [2:0] power_good,
   output var  logic       hold
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ramp [3];
   logic [1:0] phase;
   // ==========================================================
   // rails
   // each rail ramps into regulation; slow mode stretches the ramp
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 3; i++) begin
         if (!aresetn || !conv_on[i]) begin
            ramp[i] <= 4'h0;
            power_good[i] <= 1'h0;
         end else begin
            ramp[i] <= (ramp[i] == 4'hf) ? ramp[i] : ramp[i] + 4'h1;
            power_good[i] <= (ramp[i] >= (slow ? 4'h9 : 4'h2));
         end
      end
   end
   // ==========================================================
   // host
   // hold once out of reset, arm after release, let go on the next press
   always_ff @(posedge aclk) begin
      if (!aresetn || !host_en) begin
         hold <= 1'h0;
         phase <= 2'h0;
      end else begin
         case (phase)
            2'h0: if (proc_reset_n) begin
               hold <= 1'h1;
               phase <= 2'h1;
            end
            2'h1: if (button_level) phase <= 2'h2;
            2'h2: if (!button_level) begin
               hold <= 1'h0;
               phase <= 2'h3;
            end
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** verification/tb_pushbutton_power_sequencer.sv ***
/*
 * tb_pushbutton_power_sequencer: self-checking bench for psq_top.
 * Assumes psq_pkg, psq_top and psq_host_model are compiled before it.
 */
`default_nettype none
module tb_pushbutton_power_sequencer;
   import psq_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awv, wv, bre, arv, rre, host_en, slow;
   logic        awr, wr, bv, arr, rv, load, rstn, bo, boe, irq, hold, btn;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdata, rv_d;
   logic [1:0]  bresp, rresp, resp;
   logic [2:0]  pg;
   psq_in_t     pd, pins;
   psq_rail_t   rails;
   int          miscompares, n_checks, n;
   // rows: {pwm, bat, adp, adp_higher} then expected mode and supply flags
   logic [9:0]  rows [5] = '{10'h326, 10'h1df, 10'h19e, 10'h2a7, 10'h018};
   // ==========================================================
   // wiring
   // open-drain status pin has a pull-up
   assign btn = boe ? bo : 1'h1;
   always_comb begin
      pins = pd;
      pins.power_good = pg;
      pins.hold_on_input = pd.hold_on_input | hold;
   end
   psq_top #(.DEBOUNCE_CYCLES(16)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .pins(pins), .rails(rails), .protected_load_output(load), .proc_reset_n(rstn),
      .button_state_out_o(bo), .button_state_out_oe(boe), .irq(irq));
   psq_host_model host (.aclk(aclk), .aresetn(aresetn), .conv_on(rails.conv_on),
      .proc_reset_n(rstn), .button_level(btn), .host_en(host_en), .slow(slow),
      .power_good(pg), .hold(hold));
   // ==========================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tk(input int c);
      repeat (c) @(posedge aclk);
   endtask
   // ready is sampled at the falling edge so the release lands on the taking edge
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic a_ok, w_ok, b_ok;
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bre <= 1'h1;
      do begin
         @(negedge aclk);
         a_ok = awr;
         w_ok = wr;
         b_ok = bv;
         resp = bresp;
         @(posedge aclk);
         if (a_ok) awv <= 1'h0;
         if (w_ok) wv <= 1'h0;
      end while (!b_ok);
      bre <= 1'h0;
   endtask
   task automatic axr(input logic [7:0] a);
      logic a_ok, r_ok;
      @(posedge aclk);
      ara <= a;
      arv <= 1'h1;
      rre <= 1'h1;
      do begin
         @(negedge aclk);
         a_ok = arr;
         r_ok = rv;
         rv_d = rdata;
         resp = rresp;
         @(posedge aclk);
         if (a_ok) arv <= 1'h0;
      end while (!r_ok);
      rre <= 1'h0;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // clock and watchdog
   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end
   // whole sequence needs a few hundred cycles
   initial begin
      #200000;
      miscompares++;
      complete_run;
   end
   // ==========================================================
   // main sequence
   initial begin
      {aresetn, awv, wv, bre, arv, rre, host_en, slow} = 8'h00;
      {awa, ara, wd} = 48'h0;
      pd = 13'h1784; // key up, pwm high, all enables, battery only
      tk(16);
      @(negedge aclk);
      chk("reset_n in reset", rstn, 1'h0);
      chk("rails in reset", rails.conv_on, 3'h0);
      @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 5; i++) begin
         @(posedge aclk);
         {pd.pwm_select, pd.bat_present, pd.adp_present, pd.adp_higher} <= rows[i][9:6];
         tk(5);
         @(negedge aclk);
         chk("modes", {rails.force_pwm, rails.buck_auto_skip, rails.bb_skip_only, rails.ldo_on,
            rails.max_on, rails.max_from_adp}, rows[i][5:0]);
      end
      @(posedge aclk);
      {pd.pwm_select, pd.bat_present, pd.adp_present, pd.adp_higher} <= 4'hc;
      axw(REG_RST_DELAY, 32'h14);
      chk("write resp", resp, RESP_OKAY);
      axr(REG_RST_DELAY);
      chk("delay readback", rv_d, 32'h14);
      axr(8'h40);
      chk("unmapped resp", resp, RESP_SLVERR);
      axw(8'h40, 32'h0);
      chk("unmapped write resp", resp, RESP_SLVERR);
      axw(REG_INT_MASK, 32'hf);
      // a press shorter than the debounce span must do nothing
      @(posedge aclk);
      pd.key_input <= 1'h0;
      tk(8);
      pd.key_input <= 1'h1;
      tk(20);
      @(negedge aclk);
      chk("glitch status", boe, 1'h0);
      chk("glitch rails", rails.conv_on, 3'h0);
      // full power-up with the host taking over
      @(posedge aclk);
      pd.key_input <= 1'h0;
      host_en <= 1'h1;
      for (n = 0; n < 100 && !boe; n++) @(negedge aclk);
      chk("debounce span", n >= 16, 1'h1);
      chk("status low", btn, 1'h0);
      for (n = 0; n < 100 && !rails.conv_on[0]; n++) @(negedge aclk);
      chk("rail one first", rails.conv_on, 3'h1);
      for (n = 0; n < 100 && !rails.conv_on[1]; n++) @(negedge aclk);
      chk("rail two after good", pg[0], 1'h1);
      for (n = 0; n < 100 && !rails.conv_on[2]; n++) @(negedge aclk);
      chk("rail three after good", pg[1], 1'h1);
      for (n = 0; n < 100 && !load; n++) @(negedge aclk);
      chk("load after good", pg[2], 1'h1);
      chk("reset held", rstn, 1'h0);
      for (n = 0; n < 200 && !rstn; n++) @(negedge aclk);
      chk("reset delay", n >= 20 && n < 200, 1'h1);
      tk(5);
      pd.key_input <= 1'h1;
      tk(10);
      @(negedge aclk);
      chk("stays on", {rstn, rails.conv_on}, 4'hf);
      chk("irq events", irq, 1'h1);
      axr(REG_STATUS);
      chk("status word", rv_d, {20'h0000d, 6'h3f, 3'(PSQ_RUN), 3'h7});
      axr(REG_CTRL);
      chk("enabled", rv_d, 32'h1);
      axr(REG_INT_STAT);
      chk("press and ready", rv_d, 32'h3);
      axw(REG_INT_STAT, 32'hf);
      axr(REG_INT_STAT);
      chk("cleared", rv_d, 32'h0);
      chk("cleared irq", irq, 1'h0);
      // fault holds reset but keeps the rails
      pd.fault <= 1'h1;
      tk(6);
      @(negedge aclk);
      chk("fault reset", {rstn, rails.conv_on, irq}, 5'h0f);
      axw(REG_INT_MASK, 32'h0);
      tk(2);
      @(negedge aclk);
      chk("masked irq", irq, 1'h0);
      @(posedge aclk);
      pd.fault <= 1'h0;
      for (n = 0; n < 50 && !rstn; n++) @(negedge aclk);
      chk("fault gone", rstn, 1'h1);
      // second press: host lets go, release disables and discharges
      @(posedge aclk);
      pd.key_input <= 1'h0;
      for (n = 0; n < 100 && !boe; n++) @(negedge aclk);
      tk(5);
      pd.key_input <= 1'h1;
      for (n = 0; n < 20 && !rails.discharge; n++) @(negedge aclk);
      chk("discharge", {rails.discharge, rails.conv_on, rstn, load}, 6'h20);
      tk(30);
      @(negedge aclk);
      chk("discharge ends", rails.discharge, 1'h0);
      // buck two disabled is skipped; no host so release shuts down
      @(posedge aclk);
      host_en <= 1'h0;
      slow <= 1'h1;
      pd.conv_enable <= 3'h5;
      pd.key_input <= 1'h0;
      for (n = 0; n < 300 && !rails.conv_on[2]; n++) @(negedge aclk);
      chk("skip rail two", rails.conv_on, 3'h5);
      @(posedge aclk);
      pd.key_input <= 1'h1;
      for (n = 0; n < 20 && !rails.discharge; n++) @(negedge aclk);
      chk("no hold shutdown", rails.discharge, 1'h1);
      for (n = 0; n < 40 && rails.discharge; n++) @(negedge aclk);
      // hold input alone powers up; dropping an enable turns its rail off
      @(posedge aclk);
      pd.hold_on_input <= 1'h1;
      for (n = 0; n < 400 && !rstn; n++) @(negedge aclk);
      chk("hold power-up", {rstn, boe}, 2'h2);
      @(posedge aclk);
      pd.conv_enable <= 3'h4;
      tk(6);
      @(negedge aclk);
      chk("enable off", rails.conv_on, 3'h4);
      @(posedge aclk);
      pd.hold_on_input <= 1'h0;
      for (n = 0; n < 20 && !rails.discharge; n++) @(negedge aclk);
      chk("disabled reset", {rails.discharge, rstn}, 2'h2);
      complete_run;
   end
endmodule
`default_nettype wire
